// ### src/tws_pkg.sv
/*
  tws_pkg: shared constants for the two-wire slave memory port and its
  bus master end.
  assumes: both ends run on one 50 MHz system clock.
*/
package tws_pkg;
  // ----------------------------------------
  // device type field values
  // ----------------------------------------
  localparam logic [3:0] DTF_MEM   = 4'ha;
  localparam logic [3:0] DTF_LIMIT = 4'h9;
  localparam logic [3:0] DTF_CFG   = 4'hb;
  localparam logic [3:0] DTF_ALERT = 4'h1;
  // ----------------------------------------
  // array layout
  // ----------------------------------------
  localparam int MEM_WORDS   = 128;
  localparam int LIMIT_WORDS = 16;
  localparam int ADDR_W      = 7;
  localparam int PAGE_BITS   = 4;
  localparam logic [7:0] MEM_RESET = 8'hff;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ        = 50000000;
  localparam int WR_TIME_MS    = 5;
  localparam int WR_CYCLES     = (CLK_HZ / 1000) * WR_TIME_MS;
  localparam int SCL_KHZ       = 100;
  localparam int SCL_HALF_CYC  = CLK_HZ / (SCL_KHZ * 1000 * 2);
endpackage

// ### src/tws_bus_if.sv
/*
  tws_bus_if: the two-wire bus between master and slave.
  assumes: open-drain lines with pull-up; a line is low when any end
  enables its driver (drivers only ever pull low).
*/
`timescale 1ns/1ps
interface tws_bus_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // ----------------------------------------
  // wired-and resolution
  // ----------------------------------------
  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);

  modport slave  (input scl, input sda, output sda_s_oe);
  modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface

// ### src/tws_slave.sv
/*
  tws_slave: two-wire slave with a 128 x 8 array, byte and page writes,
  current, random and sequential reads.
  assumes: bus through tws_bus_if; bus-address pins are static straps.
*/
// Functional notes
// - four device type values recognised
// - address byte is type, pins, direction
// - start and stop while clock high
// - one bit per clock, data stable high
// - ninth clock carries the acknowledge
// - ack matching address and written bytes
// - read sends bytes while master acknowledges
// - nack ends reading, wait for stop
// - byte write: address, word, data, stop
// - busy write cycle ignores bus, 5 ms
// - page write up to sixteen bytes
// - only low address bits increment
// - 128 words plus sixteen limit words; the code stores only the 128 words
// - never starts a transfer
// - busy withholds address acknowledge
// - address counter is last plus one
// - reads increment all bits and wrap
`timescale 1ns/1ps
module tws_slave
  import tws_pkg::*;
#(
  parameter int WR_CYC = tws_pkg::WR_CYCLES
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // bus address straps
  input  wire logic [2:0] bus_addr_pin_i,
  // status
  output logic            busy_o,
  // bus
  tws_bus_if.slave        bus
);
  import tws_pkg::*;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WORD, ST_DATA, ST_SEND, ST_RACK, ST_WAIT
  } tws_state_type;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] scl_sync_ff, nxt_scl_sync;
  logic [2:0] sda_sync_ff, nxt_sda_sync;
  logic       scl_ff, nxt_scl, sda_ff, nxt_sda;

  always_comb begin
    nxt_scl_sync = {scl_sync_ff[1:0], bus.scl};
    nxt_sda_sync = {sda_sync_ff[1:0], bus.sda};
    nxt_scl = (scl_sync_ff[2] == scl_sync_ff[1]) ? scl_sync_ff[1] : scl_ff;
    nxt_sda = (sda_sync_ff[2] == sda_sync_ff[1]) ? sda_sync_ff[1] : sda_ff;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_ff      <= 1'b1;
      sda_ff      <= 1'b1;
    end else begin
      scl_sync_ff <= nxt_scl_sync;
      sda_sync_ff <= nxt_sda_sync;
      scl_ff      <= nxt_scl;
      sda_ff      <= nxt_sda;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = nxt_scl & ~scl_ff;
  assign scl_fall = ~nxt_scl & scl_ff;
  assign start_ev = scl_ff & nxt_scl & sda_ff & ~nxt_sda;
  assign stop_ev  = scl_ff & nxt_scl & ~sda_ff & nxt_sda;

  // ----------------------------------------
  // memory array
  // ----------------------------------------
  logic [7:0] mem_ff [MEM_WORDS];
  logic [7:0] page_ff [1 << PAGE_BITS];
  logic [(1 << PAGE_BITS)-1:0] page_vld_ff, nxt_page_vld;
  logic [ADDR_W-PAGE_BITS-1:0] page_hi_ff, nxt_page_hi;
  logic       pg_wr;
  logic [PAGE_BITS-1:0] pg_idx;

  // ----------------------------------------
  // protocol state
  // ----------------------------------------
  tws_state_type state_ff, nxt_state;
  logic [7:0]  shift_ff, nxt_shift;
  logic [3:0]  bit_ff, nxt_bit;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic        rd_ff, nxt_rd;
  logic        sda_oe_ff, nxt_sda_oe;
  logic        mem_sel_ff, nxt_mem_sel;
  logic        busy_ff, nxt_busy;
  logic        addr_set_ff, nxt_addr_set;
  logic [$clog2(WR_CYC+1)-1:0] wcnt_ff, nxt_wcnt;
  logic        match;

  assign match = (shift_ff[7:4] == DTF_MEM || shift_ff[7:4] == DTF_LIMIT
                  || shift_ff[7:4] == DTF_CFG || shift_ff[7:4] == DTF_ALERT)
                 && shift_ff[3:1] == bus_addr_pin_i;

  always_comb begin
    nxt_state    = state_ff;
    nxt_shift    = shift_ff;
    nxt_bit      = bit_ff;
    nxt_addr     = addr_ff;
    nxt_rd       = rd_ff;
    nxt_sda_oe   = sda_oe_ff;
    nxt_mem_sel  = mem_sel_ff;
    nxt_busy     = busy_ff;
    nxt_wcnt     = wcnt_ff;
    nxt_page_vld = page_vld_ff;
    nxt_page_hi  = page_hi_ff;
    pg_wr        = 1'b0;
    pg_idx       = addr_ff[PAGE_BITS-1:0];
    if (busy_ff) begin
      // inputs disabled while the array is programmed
      nxt_state  = ST_IDLE;
      nxt_sda_oe = 1'b0;
      if (wcnt_ff == WR_CYC[$bits(wcnt_ff)-1:0] - 1'b1) begin
        nxt_busy     = 1'b0;
        nxt_page_vld = '0;
      end else begin
        nxt_wcnt = wcnt_ff + 1'b1;
      end
    end else if (start_ev) begin
      // a start restarts the address phase from any state
      nxt_state  = ST_ADDR;
      nxt_bit    = 4'h0;
      nxt_sda_oe = 1'b0;
    end else if (stop_ev) begin
      nxt_state  = ST_IDLE;
      nxt_sda_oe = 1'b0;
      if (|page_vld_ff) begin
        nxt_busy = 1'b1;
        nxt_wcnt = '0;
      end
    end else begin
      case (state_ff)
        ST_ADDR, ST_WORD, ST_DATA: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_ff};
            nxt_bit   = bit_ff + 4'h1;
          end
          if (scl_fall && bit_ff == 4'h8) begin
            nxt_bit = 4'h0;
            if (state_ff == ST_ADDR) begin
              if (match) begin
                nxt_sda_oe  = 1'b1;
                nxt_rd      = shift_ff[0];
                nxt_mem_sel = shift_ff[7:4] == DTF_MEM;
                nxt_state   = ST_ACK;
              end else begin
                nxt_state = ST_WAIT;
              end
            end else if (state_ff == ST_WORD) begin
              nxt_sda_oe = 1'b1;
              nxt_addr   = shift_ff[ADDR_W-1:0];
              nxt_state  = ST_ACK;
            end else begin
              nxt_sda_oe = 1'b1;
              if (mem_sel_ff) begin
                pg_wr = 1'b1;
                nxt_page_vld[pg_idx] = 1'b1;
                nxt_page_hi = addr_ff[ADDR_W-1:PAGE_BITS];
              end
              nxt_addr = {addr_ff[ADDR_W-1:PAGE_BITS],
                          addr_ff[PAGE_BITS-1:0] + 1'b1};
              nxt_state = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_bit = 4'h0;
            if (rd_ff) begin
              nxt_sda_oe = ~mem_ff[addr_ff][7];
              nxt_shift  = {mem_ff[addr_ff][6:0], 1'b0};
              nxt_addr   = addr_ff + 1'b1;
              nxt_state  = ST_SEND;
            end else begin
              nxt_sda_oe = 1'b0;
              nxt_state  = addr_set_ff ? ST_DATA : ST_WORD;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h7) begin
              nxt_sda_oe = 1'b0;
              nxt_state  = ST_RACK;
            end else begin
              nxt_sda_oe = ~shift_ff[7];
              nxt_shift  = {shift_ff[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_ff) begin
              nxt_state = ST_WAIT;
            end else begin
              nxt_state = ST_ACK;
            end
          end
        end
        ST_WAIT: nxt_sda_oe = 1'b0;
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  // address phase tracking: first written byte is the word address
  always_comb begin
    nxt_addr_set = addr_set_ff;
    if (start_ev) begin
      nxt_addr_set = 1'b0;
    end else if (state_ff == ST_WORD && scl_fall && bit_ff == 4'h8) begin
      nxt_addr_set = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff    <= ST_IDLE;
      shift_ff    <= 8'h00;
      bit_ff      <= 4'h0;
      addr_ff     <= '0;
      rd_ff       <= 1'b0;
      sda_oe_ff   <= 1'b0;
      mem_sel_ff  <= 1'b0;
      busy_ff     <= 1'b0;
      wcnt_ff     <= '0;
      page_vld_ff <= '0;
      page_hi_ff  <= '0;
      addr_set_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      shift_ff    <= nxt_shift;
      bit_ff      <= nxt_bit;
      addr_ff     <= nxt_addr;
      rd_ff       <= nxt_rd;
      sda_oe_ff   <= nxt_sda_oe;
      mem_sel_ff  <= nxt_mem_sel;
      busy_ff     <= nxt_busy;
      wcnt_ff     <= nxt_wcnt;
      page_vld_ff <= nxt_page_vld;
      page_hi_ff  <= nxt_page_hi;
      addr_set_ff <= nxt_addr_set;
    end
  end

  // ----------------------------------------
  // page buffer and array commit
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (pg_wr) begin
      page_ff[pg_idx] <= shift_ff;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (busy_ff && wcnt_ff == '0) begin
      for (int i = 0; i < (1 << PAGE_BITS); i++) begin
        if (page_vld_ff[i]) begin
          mem_ff[{page_hi_ff, PAGE_BITS'(i)}] <= page_ff[i];
        end
      end
    end
  end

  assign bus.sda_s_oe = sda_oe_ff;
  assign busy_o       = busy_ff;
endmodule

// ### src/tws_master.sv
/*
  tws_master: two-wire bus master issuing one transfer per command.
  assumes: bus through tws_bus_if; user holds cmd until taken.
*/
`timescale 1ns/1ps
module tws_master
  import tws_pkg::*;
#(
  parameter int HALF_CYC = tws_pkg::SCL_HALF_CYC
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // command
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_byte_i,
  input  wire logic       cmd_read_i,
  input  wire logic       cmd_start_i,
  input  wire logic       cmd_stop_i,
  input  wire logic       cmd_ack_i,
  output logic            cmd_ready_o,
  // result
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_byte_o,
  output logic            rsp_nack_o,
  // bus
  tws_bus_if.master       bus
);
  import tws_pkg::*;

  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} tws_mst_type;

  tws_mst_type st_ff, nxt_st;
  logic [15:0] tick_ff, nxt_tick;
  logic [1:0]  ph_ff, nxt_ph;
  logic [3:0]  bit_ff, nxt_bit;
  logic [8:0]  sh_ff, nxt_sh;
  logic        rd_ff, nxt_rd, stop_ff, nxt_stop;
  logic        ak_ff, nxt_ak;
  logic        scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
  logic        rv_ff, nxt_rv;
  logic [7:0]  rb_ff, nxt_rb;
  logic        rn_ff, nxt_rn;
  logic        tick;

  assign tick = tick_ff == 16'(HALF_CYC - 1);

  always_comb begin
    nxt_st = st_ff; nxt_ph = ph_ff; nxt_bit = bit_ff; nxt_sh = sh_ff;
    nxt_rd = rd_ff; nxt_stop = stop_ff; nxt_rv = 1'b0; nxt_rb = rb_ff;
    nxt_rn = rn_ff; nxt_scl_oe = scl_oe_ff; nxt_sda_oe = sda_oe_ff;
    nxt_ak = ak_ff;
    nxt_tick = tick ? 16'h0000 : tick_ff + 16'h0001;
    case (st_ff)
      M_IDLE: begin
        nxt_tick = 16'h0000;
        if (cmd_valid_i) begin
          nxt_sh   = {cmd_read_i ? 8'hff : cmd_byte_i, 1'b1};
          nxt_ak   = cmd_ack_i;
          nxt_rd   = cmd_read_i;
          nxt_stop = cmd_stop_i;
          nxt_bit  = 4'h0;
          nxt_ph   = 2'h0;
          nxt_st   = cmd_start_i ? M_START : M_BIT;
        end
      end
      M_START: if (tick) begin
        nxt_ph = ph_ff + 2'h1;
        case (ph_ff)
          2'h0: begin nxt_sda_oe = 1'b0; nxt_scl_oe = 1'b0; end
          2'h1: nxt_sda_oe = 1'b1;
          default: begin nxt_scl_oe = 1'b1; nxt_ph = 2'h0; nxt_st = M_BIT; end
        endcase
      end
      M_BIT: if (tick) begin
        nxt_ph = ph_ff + 2'h1;
        case (ph_ff)
          2'h0: nxt_sda_oe = (bit_ff == 4'h8) ? (rd_ff & ak_ff)
                              : (~rd_ff & ~sh_ff[8]);
          2'h1: nxt_scl_oe = 1'b0;
          2'h2: begin
            nxt_sh = (bit_ff == 4'h8) ? sh_ff : {sh_ff[7:0], bus.sda};
            if (bit_ff == 4'h8) nxt_rn = bus.sda;
          end
          default: begin
            nxt_scl_oe = 1'b1; nxt_ph = 2'h0; nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h8) begin
              nxt_rv = 1'b1;
              nxt_rb = sh_ff[7:0];
              nxt_st = stop_ff ? M_STOP : M_IDLE;
            end
          end
        endcase
      end
      M_STOP: if (tick) begin
        nxt_ph = ph_ff + 2'h1;
        case (ph_ff)
          2'h0: nxt_sda_oe = 1'b1;
          2'h1: nxt_scl_oe = 1'b0;
          default: begin nxt_sda_oe = 1'b0; nxt_ph = 2'h0; nxt_st = M_IDLE; end
        endcase
      end
      default: nxt_st = M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= M_IDLE; tick_ff <= 16'h0000; ph_ff <= 2'h0; bit_ff <= 4'h0;
      sh_ff <= 9'h000; rd_ff <= 1'b0; stop_ff <= 1'b0; scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0; rv_ff <= 1'b0; rb_ff <= 8'h00; rn_ff <= 1'b0;
      ak_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; tick_ff <= nxt_tick; ph_ff <= nxt_ph;
      bit_ff <= nxt_bit; sh_ff <= nxt_sh; rd_ff <= nxt_rd;
      stop_ff <= nxt_stop; scl_oe_ff <= nxt_scl_oe; sda_oe_ff <= nxt_sda_oe;
      rv_ff <= nxt_rv; rb_ff <= nxt_rb; rn_ff <= nxt_rn;
      ak_ff <= nxt_ak;
    end
  end

  assign bus.scl_m_oe = scl_oe_ff;
  assign bus.sda_m_oe = sda_oe_ff;
  assign cmd_ready_o  = st_ff == M_IDLE;
  assign rsp_valid_o  = rv_ff;
  assign rsp_byte_o   = rb_ff;
  assign rsp_nack_o   = rn_ff;
endmodule

// ### test/tws_bus_asserts.sv
/*
  tws_bus_asserts: bus checks on the slave's data driver.
  assumes: wired-and lines from tws_bus_if, one clock domain.
*/
`timescale 1ns/1ps
module tws_bus_asserts
  import tws_pkg::*;
#(
  parameter logic [2:0] PINS = 3'h5
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // bus
  input  wire logic scl_m_oe,
  input  wire logic sda_m_oe,
  input  wire logic sda_s_oe,
  input  wire logic scl,
  input  wire logic sda
);
  // ----------
  // bus tracking
  // ----------
  logic       scl_ff, sda_ff, first_ff, rd_ff, acked_ff, nack_ff;
  logic       nxt_first, nxt_rd, nxt_acked, nxt_nack;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic       nine, cond, addr_ok;

  assign nine = scl & ~scl_ff & (bit_ff == 4'h8);
  assign cond = scl & scl_ff & (sda ^ sda_ff);
  assign addr_ok = (sh_ff[3:1] == PINS) &&
    (sh_ff[7:4] inside {DTF_MEM, DTF_LIMIT, DTF_CFG, DTF_ALERT});

  always_comb begin
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_first = first_ff;
    nxt_rd = rd_ff;
    nxt_acked = acked_ff;
    nxt_nack = nack_ff;
    if (nine) begin
      nxt_bit = 4'h0;
      nxt_first = 1'b0;
      if (first_ff) begin
        nxt_rd = sh_ff[0];
        nxt_acked = ~sda;
      end
      if (!first_ff && acked_ff && rd_ff && sda) begin
        nxt_nack = 1'b1;
      end
    end else if (scl && !scl_ff) begin
      nxt_bit = bit_ff + 4'h1;
      nxt_sh = {sh_ff[6:0], sda};
    end
    if (cond) begin
      nxt_bit = 4'h0;
      nxt_first = sda_ff;
      nxt_acked = 1'b0;
      nxt_nack = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      {first_ff, rd_ff, acked_ff, nack_ff} <= 4'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
      {first_ff, rd_ff, acked_ff, nack_ff} <=
        {nxt_first, nxt_rd, nxt_acked, nxt_nack};
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
    end
  end

  // ----------
  // properties
  // ----------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_idle_after_reset: assert property (
    !$past(rst_n_i) |-> scl && sda) else $error("bus busy after reset");
  a_steady_clk_high: assert property (
    scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave data moved while clock high");
  a_no_start_drive: assert property (
    $rose(sda_s_oe) |-> !scl) else $error("slave pulled data at clock high");
  a_addr_quiet: assert property (
    first_ff && bit_ff != 4'h8 |-> !sda_s_oe)
    else $error("slave drove during address byte");
  a_addr_ack_match: assert property (
    nine && first_ff && sda_s_oe |-> addr_ok)
    else $error("foreign address acknowledged");
  a_write_byte_ack: assert property (
    nine && !first_ff && acked_ff && !rd_ff |-> sda_s_oe)
    else $error("written byte not acknowledged");
  a_read_release: assert property (
    nine && !first_ff && acked_ff && rd_ff |-> !sda_s_oe)
    else $error("slave held data in read ack slot");
  a_nack_silence: assert property (
    nack_ff |-> !sda_s_oe) else $error("slave sent after master nack");

  c_addr_ack: cover property (nine && first_ff && sda_s_oe);
  c_write_ack: cover property (nine && !first_ff && !rd_ff && sda_s_oe);
  c_read_nack: cover property (nack_ff);
endmodule

// ### test/tb.sv
/*
  tb: both bus ends joined, driven through the master command port.
  assumes: slave busy time shortened by WR_CYC.
*/
`timescale 1ns/1ps
module tb;
  import tws_pkg::*;
  localparam int         WR_C = 5000;
  localparam int         HALF = 50;
  localparam int         LIM  = 20000;
  localparam int         CEIL = 90000;
  localparam logic [2:0] PINS = 3'h5;
  localparam logic [7:0] ADW  = {DTF_MEM, PINS, 1'b0};
  localparam logic [7:0] ADR  = {DTF_MEM, PINS, 1'b1};
  localparam logic [7:0] DAT [3] = '{8'h3c, 8'ha5, 8'h96};
  localparam logic [7:0] TYP [4] = '{{DTF_LIMIT, PINS, 1'b0},
    {DTF_CFG, PINS, 1'b0}, {DTF_ALERT, PINS, 1'b0}, {DTF_MEM, 3'h2, 1'b0}};

  logic       sys_clk_i, rst_n_i, busy;
  logic       cmd_valid, cmd_read, cmd_start, cmd_stop, cmd_ack;
  logic       cmd_ready, rsp_valid, rsp_nack, got_n;
  logic [7:0] cmd_byte, rsp_byte, got_b;
  int         failures, checks, cyc, bcnt;

  // ----------
  // ends and checker
  // ----------
  tws_bus_if tws_bus_if_inst ();
  tws_slave #(.WR_CYC(WR_C)) tws_slave_inst (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .bus_addr_pin_i(PINS), .busy_o(busy),
    .bus(tws_bus_if_inst));
  tws_master #(.HALF_CYC(HALF)) tws_master_inst (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte), .cmd_read_i(cmd_read),
    .cmd_start_i(cmd_start), .cmd_stop_i(cmd_stop), .cmd_ack_i(cmd_ack),
    .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_byte_o(rsp_byte), .rsp_nack_o(rsp_nack), .bus(tws_bus_if_inst));
  tws_bus_asserts #(.PINS(PINS)) tws_bus_asserts_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .scl_m_oe(tws_bus_if_inst.scl_m_oe), .sda_m_oe(tws_bus_if_inst.sda_m_oe),
    .sda_s_oe(tws_bus_if_inst.sda_s_oe), .scl(tws_bus_if_inst.scl),
    .sda(tws_bus_if_inst.sda));

  // ----------
  // clock, watchdog, busy time
  // ----------
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (busy === 1'b1) begin
      bcnt++;
    end
    if (cyc == CEIL) begin
      failures++;
      tally_and_finish();
    end
  end

  // ----------
  // tasks
  // ----------
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] b, input logic rd, st, sp, ak);
    int n;
    @(negedge sys_clk_i);
    {cmd_byte, cmd_read, cmd_start, cmd_stop, cmd_ack} = {b, rd, st, sp, ak};
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < LIM) begin
      @(negedge sys_clk_i);
      n++;
    end
    @(negedge sys_clk_i);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < LIM) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= LIM) begin
      failures++;
      tally_and_finish();
    end
    got_b = rsp_byte;
    got_n = rsp_nack;
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < LIM) begin
      @(posedge sys_clk_i);
      n++;
    end
    check({7'h0, busy}, {7'h0, lvl});
  endtask

  // ----------
  // tests
  // ----------
  initial begin
    {rst_n_i, cmd_valid, cmd_read, cmd_start, cmd_stop, cmd_ack} = 6'h0;
    cmd_byte = 8'h00;
    {failures, checks, cyc, bcnt} = {32'd0, 32'd0, 32'd0, 32'd0};
    repeat (6) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    // page write from the last word, wrapping to the page start
    xfer(ADW, 1'b0, 1'b1, 1'b0, 1'b0);
    check({7'h0, got_n}, 8'h00);
    xfer(8'h7f, 1'b0, 1'b0, 1'b0, 1'b0);
    check({7'h0, got_n}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      xfer(DAT[i], 1'b0, 1'b0, (i == 2), 1'b0);
      check({7'h0, got_n}, 8'h00);
    end
    wait_busy(1'b1);
    xfer(ADW, 1'b0, 1'b1, 1'b1, 1'b0);
    check({7'h0, got_n}, 8'h01);
    wait_busy(1'b0);
    check({7'h0, (bcnt >= WR_C - 3 && bcnt <= WR_C + 3)}, 8'h01);
    $display("test page write done");
    // random read at the wrapped page start, then sequential
    xfer(ADW, 1'b0, 1'b1, 1'b0, 1'b0);
    xfer(8'h70, 1'b0, 1'b0, 1'b0, 1'b0);
    xfer(ADR, 1'b0, 1'b1, 1'b0, 1'b0);
    check({7'h0, got_n}, 8'h00);
    xfer(8'h00, 1'b1, 1'b0, 1'b0, 1'b1);
    check(got_b, DAT[1]);
    xfer(8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
    check(got_b, DAT[2]);
    $display("test read done");
    // other device types, and a foreign bus address
    for (int i = 0; i < 4; i++) begin
      xfer(TYP[i], 1'b0, 1'b1, 1'b1, 1'b0);
      check({7'h0, got_n}, {7'h0, (i == 3)});
    end
    $display("test types done");
    tally_and_finish();
  end
endmodule
